// file: src/usw_pkg.sv
/*
 usw_pkg: register map, field positions, reset values, timing counts and
 states of the usb suspend and wake event block.
 assumes a 100 mhz pclk and a 32-bit apb master.
*/
// Notes on behaviour
// RQ1: idle condition sets suspend request, status bit 4
// RQ2: suspend/reset flags clear only on write one
// RQ3: port reset sets bit 5; reset never clears
// RQ4: suspend sequence starts after 3 ms idle
// RQ5: full speed: set suspend flag, raise interrupt
// RQ6: high speed: revert within 0.125 ms first
// RQ7: firmware clears suspend flag within 10 ms
// RQ8: clear enters suspend; clock stops if low-power
// RQ9: no resume before 5 ms continuous idle
// RQ10: one-cycle pulse per pin change, ored
// RQ11: summary sets if clear, clocked, and enabled
// RQ12: pending summary blocks further interrupts
// RQ13: summary clear keeps per-source flags set
// RQ14: firmware clears summary before source flags
// RQ15: firmware reads sources, services each one
// RQ16: write one clears each per-source flag
// RQ17: summary is status bit 2, five pins
// RQ18: control bit 6 gates clock stop in suspend
// RQ19: resume on summary clear or 10 ms later
// RQ20: interrupt stays high while enabled flag set
package usw_pkg;
	localparam logic [7:0] STATUS_OFS = 8'h00;
	localparam logic [7:0] MASK_OFS = 8'h04;
	localparam logic [7:0] CONTROL_OFS = 8'h08;
	localparam logic [7:0] SOURCE_OFS = 8'h0C;
	localparam logic [7:0] SRC_EN_OFS = 8'h10;
	localparam int WAKE_BIT = 2;
	localparam int SUSP_BIT = 4;
	localparam int RST_BIT = 5;
	localparam int RWAKE_BIT = 5;
	localparam int LOW_POWER_ENABLE_BIT = 6;
	localparam int NSRC = 5;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [3:0] SRC_EN_RST = 4'h0;
	localparam int CLK_MHZ = 100;
	localparam int IDLE_US = 3000;
	localparam int REVERT_NS = 125000;
	localparam int RESUME_IDLE_US = 5000;
	localparam int RESUME_WAIT_US = 10000;
	localparam int RESUME_LEN_US = 1000;
	localparam int IDLE_CYC = IDLE_US * CLK_MHZ;
	localparam int REVERT_CYC = REVERT_NS * CLK_MHZ / 1000;
	localparam int RESUME_IDLE_CYC = RESUME_IDLE_US * CLK_MHZ;
	localparam int RESUME_WAIT_CYC = RESUME_WAIT_US * CLK_MHZ;
	localparam int RESUME_LEN_CYC = RESUME_LEN_US * CLK_MHZ;
	localparam int CNT_W = 21;
	typedef enum logic [2:0] {
		ST_ACTIVE = 3'b000,
		ST_REVERT = 3'b001,
		ST_REQUEST = 3'b010,
		ST_SUSPEND = 3'b011,
		ST_RESUME = 3'b100
	} usw_state_e;
endpackage : usw_pkg

// file: src/usw_suspend_wake.sv
/*
 usw_suspend_wake: bus idle watch, suspend request, port reset flag,
 pin-change wake events and remote wakeup resume, behind an apb slave.
 assumes bus_idle, bus_reset, high_speed and the five wake pins come from
 outside pclk; the phy acts on fs_revert and resume_drive.
*/
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module usw_suspend_wake #(
	parameter int IDLE_CYC = usw_pkg::IDLE_CYC,
	parameter int REVERT_CYC = usw_pkg::REVERT_CYC,
	parameter int RESUME_IDLE_CYC = usw_pkg::RESUME_IDLE_CYC,
	parameter int RESUME_WAIT_CYC = usw_pkg::RESUME_WAIT_CYC,
	parameter int RESUME_LEN_CYC = usw_pkg::RESUME_LEN_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bus_idle,
	input wire logic bus_reset,
	input wire logic high_speed,
	input wire logic bus_power_pin,
	input wire logic wake_gpio_pin_a,
	input wire logic wake_gpio_pin_b,
	input wire logic card_detect_pin_a,
	input wire logic card_detect_pin_b,
	output logic irq,
	output logic fs_revert,
	output logic suspended,
	output logic core_clk_stop,
	output logic resume_drive
);
	localparam int W = usw_pkg::CNT_W;

	// pins and phy levels: two flops, then a third for edges
	logic [7:0] pin_raw;
	logic [7:0] sync1_r;
	logic [7:0] sync2_r;
	logic [7:0] prev_r;
	assign pin_raw = {high_speed, bus_reset, bus_idle, card_detect_pin_b,
		card_detect_pin_a, wake_gpio_pin_b, wake_gpio_pin_a, bus_power_pin};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= 8'h00;
			sync2_r <= 8'h00;
			prev_r <= 8'h00;
		end else begin
			sync1_r <= pin_raw;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	wire idle_s = sync2_r[5];
	wire reset_s = sync2_r[6];
	wire hs_s = sync2_r[7];
	wire reset_rise = reset_s & ~prev_r[6];

	// apb: one wait state so read data leaves a flop
	logic ack_r;
	logic [31:0] prdata_r;
	logic [7:0] mask_r;
	logic [7:0] control_r;
	logic [3:0] src_en_r;
	logic wake_sum_r;
	logic susp_req_r;
	logic rst_req_r;
	logic [usw_pkg::NSRC-1:0] src_r;
	logic wake_pend_r;

	wire [7:0] ofs = paddr[7:0];
	wire hi_zero = (paddr[31:8] == 24'h00_0000);
	wire sel_sta = hi_zero & (ofs == usw_pkg::STATUS_OFS);
	wire sel_msk = hi_zero & (ofs == usw_pkg::MASK_OFS);
	wire sel_ctl = hi_zero & (ofs == usw_pkg::CONTROL_OFS);
	wire sel_src = hi_zero & (ofs == usw_pkg::SOURCE_OFS);
	wire sel_sen = hi_zero & (ofs == usw_pkg::SRC_EN_OFS);
	wire hit = sel_sta | sel_msk | sel_ctl | sel_src | sel_sen;
	wire first = psel & penable & ~ack_r;
	wire wr = psel & penable & ack_r & pwrite;
	assign pready = ack_r;
	assign pslverr = ack_r & ~hit;
	assign prdata = prdata_r;

	logic [7:0] status_v;
	always_comb begin
		status_v = 8'h00;
		status_v[usw_pkg::WAKE_BIT] = wake_sum_r;
		status_v[usw_pkg::SUSP_BIT] = susp_req_r;
		status_v[usw_pkg::RST_BIT] = rst_req_r;
	end

	wire [31:0] rd_mux =
		sel_sta ? {24'h00_0000, status_v} :
		sel_msk ? {24'h00_0000, mask_r} :
		sel_ctl ? {24'h00_0000, control_r} :
		sel_src ? {27'h000_0000, src_r} :
		sel_sen ? {28'h000_0000, src_en_r} : 32'h0000_0000;

	// write-one-clear strobes; reserved status bits stay zero
	wire clr_wake = wr & sel_sta & pwdata[usw_pkg::WAKE_BIT];
	wire clr_susp = wr & sel_sta & pwdata[usw_pkg::SUSP_BIT]; // RQ2
	wire clr_rst = wr & sel_sta & pwdata[usw_pkg::RST_BIT]; // RQ2
	wire [usw_pkg::NSRC-1:0] clr_src =
		(wr & sel_src) ? pwdata[usw_pkg::NSRC-1:0] : '0;
	wire [7:0] mask_wmask = 8'h34;
	wire [7:0] ctl_wmask = 8'h60;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			mask_r <= usw_pkg::MASK_RST;
			control_r <= usw_pkg::CONTROL_RST;
			src_en_r <= usw_pkg::SRC_EN_RST;
		end else begin
			ack_r <= first;
			if (first) begin
				prdata_r <= rd_mux;
			end
			if (wr & sel_msk) begin
				mask_r <= pwdata[7:0] & mask_wmask;
			end
			if (wr & sel_ctl) begin
				control_r <= pwdata[7:0] & ctl_wmask;
			end
			if (wr & sel_sen) begin
				src_en_r <= pwdata[3:0];
			end
		end
	end

	wire low_power_enable = control_r[usw_pkg::LOW_POWER_ENABLE_BIT];
	wire rwake = control_r[usw_pkg::RWAKE_BIT];
	wire wake_en = mask_r[usw_pkg::WAKE_BIT];

	// pin change pulses; bus power detection cannot be switched off
	logic [usw_pkg::NSRC-1:0] det;
	genvar g;
	generate
		for (g = 0; g < usw_pkg::NSRC; g++) begin : g_det
			if (g == 0) begin : g_vbus
				assign det[g] = sync2_r[g] ^ prev_r[g]; // RQ10
			end else begin : g_gpio
				assign det[g] = (sync2_r[g] ^ prev_r[g]) & src_en_r[g-1]; // RQ10
			end
		end
	endgenerate
	wire any_det = |det; // RQ10 RQ17

	// state machine and counters
	usw_pkg::usw_state_e state_r;
	usw_pkg::usw_state_e state_nxt;
	logic [W-1:0] idle_cnt_r;
	logic [W-1:0] tmr_r;
	logic stop_r;
	wire clk_run = ~stop_r;

	wire idle_done = (idle_cnt_r >= W'(IDLE_CYC)); // RQ4
	wire resume_ok = (idle_cnt_r >= W'(RESUME_IDLE_CYC)); // RQ9
	wire wait_done = (tmr_r >= W'(RESUME_WAIT_CYC)); // RQ19
	// tmr starts at zero on entry, so revert lasts exactly REVERT_CYC cycles
	wire rev_done = (tmr_r >= W'(REVERT_CYC - 1)); // RQ6
	wire len_done = (tmr_r >= W'(RESUME_LEN_CYC));
	// the remote wake timer only runs once the summary has fired
	wire res_trig = rwake & wake_en & resume_ok & (clr_wake | wait_done); // RQ9 RQ19

	wire set_susp_fs = (state_r == usw_pkg::ST_ACTIVE) & idle_done & ~hs_s; // RQ5
	wire set_susp_hs = (state_r == usw_pkg::ST_REVERT) & rev_done; // RQ6
	wire set_susp = set_susp_fs | set_susp_hs; // RQ1

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			usw_pkg::ST_ACTIVE: begin
				if (idle_done) begin
					state_nxt = hs_s ? usw_pkg::ST_REVERT : usw_pkg::ST_REQUEST; // RQ4
				end
			end
			usw_pkg::ST_REVERT: begin
				if (rev_done) begin
					state_nxt = usw_pkg::ST_REQUEST; // RQ6
				end
			end
			usw_pkg::ST_REQUEST: begin
				if (!idle_s) begin
					state_nxt = usw_pkg::ST_ACTIVE;
				end else if (!susp_req_r) begin
					state_nxt = usw_pkg::ST_SUSPEND; // RQ8
				end
			end
			usw_pkg::ST_SUSPEND: begin
				if (!idle_s) begin
					state_nxt = usw_pkg::ST_ACTIVE;
				end else if (wake_sum_r & res_trig) begin
					state_nxt = usw_pkg::ST_RESUME; // RQ19
				end
			end
			usw_pkg::ST_RESUME: begin
				if (len_done) begin
					state_nxt = usw_pkg::ST_ACTIVE;
				end
			end
			default: state_nxt = usw_pkg::ST_ACTIVE;
		endcase
		if (reset_s) begin
			state_nxt = usw_pkg::ST_ACTIVE;
		end
	end

	wire st_chg = (state_nxt != state_r);
	// host resume or remote wake restarts the clock
	wire wake_clk = rwake & wake_en & any_det;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= usw_pkg::ST_ACTIVE;
			idle_cnt_r <= '0;
			tmr_r <= '0;
			stop_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (!idle_s) begin
				idle_cnt_r <= '0;
			end else if (idle_cnt_r != {W{1'b1}}) begin
				idle_cnt_r <= idle_cnt_r + W'(1);
			end
			if (st_chg | (state_r == usw_pkg::ST_SUSPEND & ~wake_sum_r)) begin
				tmr_r <= '0;
			end else if (tmr_r != {W{1'b1}}) begin
				tmr_r <= tmr_r + W'(1);
			end
			if (st_chg & (state_nxt == usw_pkg::ST_SUSPEND)) begin
				stop_r <= low_power_enable; // RQ8 RQ18
			end else if (state_nxt != usw_pkg::ST_SUSPEND | wake_clk) begin
				stop_r <= 1'b0;
			end
		end
	end

	// status flags: a set in the clearing cycle wins, except for the summary, where the clear wins
	wire sum_set = (any_det | wake_pend_r) & clk_run & wake_en & ~wake_sum_r; // RQ11 RQ12

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			susp_req_r <= 1'b0;
			rst_req_r <= 1'b0;
			wake_sum_r <= 1'b0;
			wake_pend_r <= 1'b0;
			src_r <= '0;
		end else begin
			susp_req_r <= set_susp | (susp_req_r & ~clr_susp); // RQ1 RQ2
			rst_req_r <= reset_rise | (rst_req_r & ~clr_rst); // RQ3 RQ2
			wake_sum_r <= sum_set | (wake_sum_r & ~clr_wake); // RQ11 RQ13
			// events seen while stopped are kept until the clock runs
			if (sum_set) begin
				wake_pend_r <= 1'b0;
			end else if (any_det & ~clk_run) begin
				wake_pend_r <= 1'b1;
			end
			src_r <= det | (src_r & ~clr_src); // RQ13 RQ16
		end
	end

	assign irq = |(status_v & mask_r); // RQ20
	assign fs_revert = (state_r == usw_pkg::ST_REVERT); // RQ6
	assign suspended = (state_r == usw_pkg::ST_SUSPEND);
	assign core_clk_stop = stop_r; // RQ8
	assign resume_drive = (state_r == usw_pkg::ST_RESUME); // RQ9
endmodule : usw_suspend_wake
`default_nettype wire

// file: verification/usw_checker.sv
/* usw_checker: port assertions for usw_suspend_wake.
 assumes a bind from the bench top and shortened counts. */
`timescale 1ns/1ps
`default_nettype none
module usw_checker #(
	parameter int RESUME_IDLE_CYC = 60
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic bus_idle,
	input wire logic fs_revert,
	input wire logic suspended,
	input wire logic core_clk_stop,
	input wire logic resume_drive
);
	// raw pin count, runs ahead of the synced one, so the bound is safe
	logic [20:0] idle_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) idle_r <= 21'h0;
		else idle_r <= bus_idle ? idle_r + 21'h1 : 21'h0;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rdy_one; pready |=> !pready; endproperty
	a_rdy_one: assert property (p_rdy_one) else $error("long pready");
	property p_rdy_acc; pready |-> psel && penable && $past(penable);
	endproperty
	a_rdy_acc: assert property (p_rdy_acc) else $error("stray pready");
	property p_err_rdy; pslverr |-> pready; endproperty
	a_err_rdy: assert property (p_err_rdy) else $error("stray pslverr");
	property p_revert; $rose(fs_revert) |=> fs_revert [*8]; endproperty
	a_revert: assert property (p_revert) else $error("short revert");
	property p_stop; core_clk_stop |-> suspended; endproperty
	a_stop: assert property (p_stop) else $error("clock stop awake");
	property p_res_from; $rose(resume_drive) |-> $past(suspended);
	endproperty
	a_res_from: assert property (p_res_from) else $error("resume");
	property p_res_len; $rose(resume_drive) |=> resume_drive [*8];
	endproperty
	a_res_len: assert property (p_res_len) else $error("short resume");
	property p_res_idle; $rose(resume_drive) |-> idle_r >= RESUME_IDLE_CYC;
	endproperty
	a_res_idle: assert property (p_res_idle) else $error("early");
	c_susp: cover property ($rose(suspended));
	c_res: cover property ($rose(resume_drive));
	c_err: cover property (pslverr);
endmodule : usw_checker
`default_nettype wire

// file: verification/usw_host_model.sv
/* usw_host_model: upstream host, drives idle, port reset and speed.
 assumes callers enter its task right after a rising pclk edge. */
`timescale 1ns/1ps
`default_nettype none
module usw_host_model (
	input wire logic pclk,
	output logic bus_idle,
	output logic bus_reset,
	output logic high_speed
);
	initial begin
		bus_idle = 1'b0;
		bus_reset = 1'b0;
		high_speed = 1'b0;
	end
	// port reset is never idle: callers pass idle low with it
	task automatic drive(input logic idle, input logic rst, input logic hs);
		@(posedge pclk);
		bus_idle <= idle;
		bus_reset <= rst;
		high_speed <= hs;
	endtask : drive
endmodule : usw_host_model
`default_nettype wire

// file: verification/usw_suspend_wake_tb_top.sv
/* usw_suspend_wake_tb_top: apb driver, read scoreboard and scenarios.
 assumes one wait state apb and the shortened counts set below. */
`timescale 1ns/1ps
`default_nettype none
module usw_suspend_wake_tb_top;
	localparam int IDLE = 40;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, irq, fs_revert, suspended;
	logic core_clk_stop, resume_drive, bus_idle, bus_reset, high_speed;
	logic [31:0] paddr = '0, pwdata = '0, prdata;
	logic [4:0] pins = '0;
	logic [32:0] expq[$];
	int err_total = 0, compares = 0, n, i, j;
	always #5 pclk = ~pclk;
	usw_host_model u_host (.pclk(pclk), .bus_idle(bus_idle),
		.bus_reset(bus_reset), .high_speed(high_speed));
	usw_suspend_wake #(.IDLE_CYC(IDLE), .REVERT_CYC(10), .RESUME_IDLE_CYC(60),
		.RESUME_WAIT_CYC(100), .RESUME_LEN_CYC(20)) u_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus_idle(bus_idle), .bus_reset(bus_reset),
		.high_speed(high_speed), .bus_power_pin(pins[0]),
		.wake_gpio_pin_a(pins[1]), .wake_gpio_pin_b(pins[2]),
		.card_detect_pin_a(pins[3]), .card_detect_pin_b(pins[4]), .irq(irq),
		.fs_revert(fs_revert), .suspended(suspended),
		.core_clk_stop(core_clk_stop), .resume_drive(resume_drive));
	task automatic end_of_test();
		$display("err_total %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	task automatic check(input logic [32:0] exp, input logic [32:0] act);
		compares++;
		if (act !== exp) begin
			err_total++;
			$display("[FAIL] %0t exp %h got %h", $time, exp, act);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			$display("[FAIL] %0t apb timeout", $time);
			err_total++;
			end_of_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [31:0] a, input logic [32:0] exp);
		expq.push_back(exp);
		apb(1'b0, a, 32'h0);
	endtask : rd
	// reads are judged here, when the answer shows, against the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (expq.size() > 0) check(expq.pop_front(), {pslverr, prdata});
			else check(33'h0, 33'h1);
		end
	end
	task automatic wait_hi(input int sel, input int lim, output int c);
		c = 0;
		while ((sel == 0 ? irq : sel == 1 ? fs_revert : resume_drive) !== 1'b1
			&& c < lim) begin
			@(posedge pclk);
			c++;
		end
		if (c >= lim) begin
			$display("[FAIL] %0t wait timeout", $time);
			err_total++;
			end_of_test();
		end
	endtask : wait_hi
	task automatic poke(input int p);
		pins[p] <= ~pins[p];
		repeat (6) @(posedge pclk);
	endtask : poke
	initial begin
		n = $urandom(21);
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		for (int a = 0; a < 6; a++) rd(32'(a * 4), a == 5 ? 33'h1_0000_0000 : 33'h0);
		apb(1'b1, 32'h4, 32'hFF);
		apb(1'b1, 32'h8, 32'hFF);
		apb(1'b1, 32'h10, 32'hFF);
		rd(32'h4, 33'h34);
		rd(32'h8, 33'h60);
		rd(32'h10, 33'hF);
		for (int p = 0; p < 5; p++) begin
			poke(p);
			check(33'h1, {32'h0, irq});
			rd(32'h0, 33'h4);
			apb(1'b1, 32'h0, 32'h4);
			rd(32'hC, 33'(1 << p));
			apb(1'b1, 32'hC, 32'(1 << p));
			rd(32'hC, 33'h0);
		end
		poke(1);
		poke(3);
		apb(1'b1, 32'h0, 32'h4);
		check(33'h0, {32'h0, irq});
		rd(32'hC, 33'hA);
		apb(1'b1, 32'h4, 32'h30);
		poke(2);
		rd(32'h0, 33'h0);
		apb(1'b1, 32'hC, 32'hF);
		apb(1'b1, 32'h4, 32'h34);
		u_host.drive(1'b0, 1'b1, 1'b0);
		repeat (8) @(posedge pclk);
		rd(32'h0, 33'h20);
		apb(1'b1, 32'h0, 32'h0);
		rd(32'h0, 33'h20);
		u_host.drive(1'b0, 1'b0, 1'b0);
		apb(1'b1, 32'h0, 32'h20);
		rd(32'h0, 33'h0);
		u_host.drive(1'b1, 1'b0, 1'b0);
		wait_hi(0, IDLE + 20, n);
		check(33'h1, {32'h0, n >= IDLE});
		rd(32'h0, 33'h10);
		apb(1'b1, 32'h0, 32'h10);
		repeat (2) @(posedge pclk);
		check(33'h3, {31'h0, suspended, core_clk_stop});
		i = $urandom % 5;
		j = (i + 1 + $urandom % 4) % 5;
		poke(i);
		poke(j);
		check(33'h1, {32'h0, irq});
		apb(1'b1, 32'h0, 32'h4);
		wait_hi(2, 150, n);
		rd(32'hC, 33'((1 << i) | (1 << j)));
		apb(1'b1, 32'hC, 32'h1F);
		u_host.drive(1'b0, 1'b0, 1'b1);
		repeat (40) @(posedge pclk);
		u_host.drive(1'b1, 1'b0, 1'b1);
		wait_hi(1, IDLE + 20, n);
		check(33'h0, {32'h0, irq});
		wait_hi(0, 40, n);
		check(33'h1, {32'h0, n >= 9 && n <= 10});
		rd(32'h0, 33'h10);
		// summary left pending: resume must wait for the timer, not a clear
		apb(1'b1, 32'h0, 32'h10);
		poke(0);
		wait_hi(2, 150, n);
		check(33'h1, {32'h0, n >= 96 && n <= 102});
		rd(32'hC, 33'h1);
		end_of_test();
	end
endmodule : usw_suspend_wake_tb_top
bind usw_suspend_wake usw_checker #(.RESUME_IDLE_CYC(RESUME_IDLE_CYC)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .bus_idle(bus_idle),
	.fs_revert(fs_revert), .suspended(suspended),
	.core_clk_stop(core_clk_stop), .resume_drive(resume_drive));
`default_nettype wire
